// File: logic/hct_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * Hall calibration and test register bank.
 * Assumes a 100 MHz pclk and an APB master with 32-bit data.
 */
`ifndef HCT_MAP_SVH
`define HCT_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define HCT_IDX_GAIN       6'h00
`define HCT_IDX_RATIO      6'h01
`define HCT_IDX_SIN_OFS    6'h02
`define HCT_IDX_COS_OFS    6'h03
`define HCT_IDX_BIAS       6'h04
`define HCT_IDX_TEST       6'h0e
`define HCT_IDX_STATUS     6'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HCT_BIT_AUTO       7
`define HCT_BIT_PSAVE      7
`define HCT_BIT_SCLK       7
`define HCT_OFS_NEG_BIT    6
`define HCT_BIAS_MSB       3

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define HCT_RST_REG        8'h00
`define HCT_BIAS_NOMINAL   4'h8
`define HCT_TEST_NORMAL    8'h00
`define HCT_TEST_SIN       8'h20
`define HCT_TEST_COS       8'h21
`define HCT_TEST_INTERP    8'h22
`define HCT_TEST_REF       8'h43
`define HCT_TEST_CLK       8'hc0
`define HCT_BIAS_STEP_PCT  8'h05
`define HCT_BIAS_MIN_PCT   8'h28
`define HCT_PSAVE_SHIFT    2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HCT_CLK_NS         10
`define HCT_SCLK_LOW_KHZ   250
`define HCT_SCLK_HIGH_KHZ  500
`define HCT_BIAS_DERIVED_CLOCK_NOM_KHZ   1000
`define HCT_SCLK_LOW_HALF  (1000000 / (`HCT_SCLK_LOW_KHZ * `HCT_CLK_NS * 2))
`define HCT_SCLK_HIGH_HALF (1000000 / (`HCT_SCLK_HIGH_KHZ * `HCT_CLK_NS * 2))
`define HCT_BIAS_DERIVED_CLOCK_NOM_HALF  (1000000 / (`HCT_BIAS_DERIVED_CLOCK_NOM_KHZ * `HCT_CLK_NS * 2))
`define HCT_BIAS_DEN       20
`define HCT_BIAS_CODE_OFS  12

`endif

// File: logic/hct_pkg.sv
/*
 * Types of the Hall calibration and test register bank.
 * Assumes hct_map.svh is on the include path.
 */
`default_nettype none

package hct_pkg;

	typedef enum logic [2:0] {
		HCT_ROUTE_NORMAL,
		HCT_ROUTE_SIN,
		HCT_ROUTE_COS,
		HCT_ROUTE_INTERP,
		HCT_ROUTE_REF,
		HCT_ROUTE_CLK
	} hct_route_type;

	typedef enum logic [2:0] {
		HCT_SEL_GAIN,
		HCT_SEL_RATIO,
		HCT_SEL_SIN,
		HCT_SEL_COS,
		HCT_SEL_BIAS,
		HCT_SEL_TEST,
		HCT_SEL_STATUS,
		HCT_SEL_NONE
	} hct_sel_type;

	typedef struct packed {
		logic          pready;
		logic          pslverr;
		logic [7:0]    prdata;
		logic [7:0]    gain;
		logic [7:0]    ratio;
		logic [7:0]    sin_ofs;
		logic [7:0]    cos_ofs;
		logic [3:0]    bias_trim;
		logic [3:0]    bias_preset;
		logic          sclk_sel;
		logic [7:0]    test_code;
		hct_route_type route;
		logic          test_active;
		logic [6:0]    sin_mv;
		logic [6:0]    cos_mv;
		logic [7:0]    bias_pct;
		logic [7:0]    sclk_cnt;
		logic          sclk;
		logic [7:0]    bias_derived_clock_cnt;
		logic          bias_derived_clock;
		logic          pin_a;
		logic          pin_b;
		logic          pin_z;
		logic          pin_u;
		logic          pin_digital_enable;
		logic [1:0]    rot_shift;
		logic [5:0]    fine_applied;
	} hct_state_type;

endpackage

`default_nettype wire

// File: logic/hct_offset_decode.sv
/*
 * Converts one sign-magnitude offset trim code into a signed millivolt value.
 * Purely combinational; the parent registers the result.
 */
`default_nettype none

module hct_offset_decode (
	input  wire logic [6:0] code,
	output logic      [6:0] offset_mv
);

	// --------------------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------------------
	// Both 0x00 and 0x40 mean zero, so the negative zero folds to plain zero.
	always_comb begin
		if (code[6]) begin
			offset_mv = 7'(7'h00 - {1'b0, code[5:0]});
		end else begin
			offset_mv = {1'b0, code[5:0]};
		end
	end

endmodule

`default_nettype wire

// File: logic/hct_regs.sv
/*
 * Hall front-end calibration and test register bank with an APB slave.
 * Holds offset trims, power save, bias trim with fuse preset, sensor clock
 * selection, gain controls and the test-mode output routing of pins A/B/Z/U.
 * Assumes pclk at 100 MHz, inputs synchronous to pclk, and a fuse loader that
 * pulses fuse_load_valid once the fuse ROM has been read.
 */
// Added by the designer: the APB slave port.
// Contract
// - Each 7-bit offset trim is sign-magnitude in 1 mV steps, 0x00-0x3F positive, 0x40-0x7F negative, one for sine and one for cosine.
// - Power save set in bit 7 of the cosine offset register quarters the Hall drive current and cuts the top rotation frequency by four.
// - The 4-bit bias trim scales bias current in 5 percent steps, 0x0 is -40, 0x8 nominal, 0xF +35 percent.
// - The bias trim takes its factory preset from the fuse memory.
// - The working bias trim stays writable at run time without touching the stored preset.
// - Sensor clock select bit 7 of register 0x04 picks 250 kHz when 0 and 500 kHz when 1.
// - Test mode is entered only while the programming pin is at supply and a test code is in register 0x0E.
// - Test code 0x00 gives normal pins, 0x20 sine sensor paths, 0x21 cosine paths, 0x22 interpolator inputs.
// - Test code 0x43 routes the references to A, Z, U and the bias current to B.
// - Test code 0xC0 puts a bias-derived clock on pin A, nominally 1 MHz.
// - With auto amplitude on the fine gain field is ignored; with it off the field sets the second stage.
`default_nettype none

`include "hct_map.svh"

module hct_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  fuse_load_valid,
	input  wire logic [3:0]            fuse_bias_trim,
	input  wire logic                  programming_voltage_pin_at_supply,
	input  wire logic                  norm_a,
	input  wire logic                  norm_b,
	input  wire logic                  norm_z,
	input  wire logic                  norm_u,
	output logic                       pin_a,
	output logic                       pin_b,
	output logic                       pin_z,
	output logic                       pin_u,
	output logic                       pin_digital_enable,
	output hct_pkg::hct_route_type     analog_route,
	output logic                       test_mode_active,
	output logic      [6:0]            sine_offset_mv,
	output logic      [6:0]            cosine_offset_mv,
	output logic                       power_save_flag,
	output logic      [1:0]            rotation_limit_shift,
	output logic      [3:0]            bias_current_trim,
	output logic      [7:0]            bias_current_pct,
	output logic                       sensor_clock_select,
	output logic                       hall_switch_clk,
	output logic                       auto_amplitude_enable,
	output logic      [1:0]            coarse_gain,
	output logic      [5:0]            fine_gain_applied,
	output logic      [6:0]            cosine_ratio_trim
);

	// --------------------------------------------------------------------------
	// Constants and functions
	// --------------------------------------------------------------------------
	localparam logic [7:0] SCLK_LOW_HALF  = 8'(`HCT_SCLK_LOW_HALF);
	localparam logic [7:0] SCLK_HIGH_HALF = 8'(`HCT_SCLK_HIGH_HALF);
	localparam int         BIAS_DERIVED_CLOCK_NUM       = `HCT_BIAS_DERIVED_CLOCK_NOM_HALF * `HCT_BIAS_DEN;

	// Word-aligned addresses only; a byte offset inside a word is unmapped.
	function automatic hct_pkg::hct_sel_type reg_sel(input logic [7:0] addr);
		hct_pkg::hct_sel_type sel;
		sel = hct_pkg::HCT_SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[7:2])
				`HCT_IDX_GAIN:    sel = hct_pkg::HCT_SEL_GAIN;
				`HCT_IDX_RATIO:   sel = hct_pkg::HCT_SEL_RATIO;
				`HCT_IDX_SIN_OFS: sel = hct_pkg::HCT_SEL_SIN;
				`HCT_IDX_COS_OFS: sel = hct_pkg::HCT_SEL_COS;
				`HCT_IDX_BIAS:    sel = hct_pkg::HCT_SEL_BIAS;
				`HCT_IDX_TEST:    sel = hct_pkg::HCT_SEL_TEST;
				`HCT_IDX_STATUS:  sel = hct_pkg::HCT_SEL_STATUS;
				default:          sel = hct_pkg::HCT_SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	function automatic hct_pkg::hct_route_type route_of(input logic [7:0] code);
		hct_pkg::hct_route_type r;
		case (code)
			`HCT_TEST_SIN:    r = hct_pkg::HCT_ROUTE_SIN;
			`HCT_TEST_COS:    r = hct_pkg::HCT_ROUTE_COS;
			`HCT_TEST_INTERP: r = hct_pkg::HCT_ROUTE_INTERP;
			`HCT_TEST_REF:    r = hct_pkg::HCT_ROUTE_REF;
			`HCT_TEST_CLK:    r = hct_pkg::HCT_ROUTE_CLK;
			default:          r = hct_pkg::HCT_ROUTE_NORMAL;
		endcase
		return r;
	endfunction

	// Half period of the bias clock: nominal at code 0x8, inversely to the
	// current scale (12 + code) / 20, so a larger trim gives a faster clock.
	function automatic logic [7:0] bias_derived_clock_half(input logic [3:0] trim);
		int den;
		den = `HCT_BIAS_CODE_OFS + int'(trim);
		return 8'(BIAS_DERIVED_CLOCK_NUM / den);
	endfunction

	// --------------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------------
	hct_pkg::hct_state_type state_r;
	hct_pkg::hct_state_type state_nxt;
	logic [6:0]             ofs_code [2];
	logic [6:0]             ofs_mv   [2];
	hct_pkg::hct_sel_type   sel;
	logic                   acc;

	assign ofs_code[0] = state_r.sin_ofs[6:0];
	assign ofs_code[1] = state_r.cos_ofs[6:0];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ofs
			hct_offset_decode u_dec (
				.code      (ofs_code[ch]),
				.offset_mv (ofs_mv[ch])
			);
		end
	endgenerate

	assign sel = reg_sel(paddr);
	assign acc = psel && penable;

	// --------------------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------------------
	always_comb begin
		logic [7:0] sclk_half;
		logic [7:0] rd;
		sclk_half = SCLK_LOW_HALF;
		rd        = 8'h00;
		state_nxt = state_r;

		// APB: one wait state, then pready with read data or error.
		state_nxt.pready  = acc && !state_r.pready;
		state_nxt.pslverr = acc && !state_r.pready && (sel == hct_pkg::HCT_SEL_NONE);
		case (sel)
			hct_pkg::HCT_SEL_GAIN:   rd = state_r.gain;
			hct_pkg::HCT_SEL_RATIO:  rd = state_r.ratio;
			hct_pkg::HCT_SEL_SIN:    rd = state_r.sin_ofs;
			hct_pkg::HCT_SEL_COS:    rd = state_r.cos_ofs;
			hct_pkg::HCT_SEL_BIAS:   rd = {state_r.sclk_sel, 3'h0, state_r.bias_trim};
			hct_pkg::HCT_SEL_TEST:   rd = state_r.test_code;
			hct_pkg::HCT_SEL_STATUS: rd = {state_r.bias_preset, state_r.route, state_r.test_active};
			default:                 rd = 8'h00;
		endcase
		if (acc && !state_r.pready) begin
			state_nxt.prdata = pwrite ? 8'h00 : rd;
		end

		// Writes land at the edge that completes the access.
		if (acc && state_r.pready && pwrite) begin
			case (sel)
				hct_pkg::HCT_SEL_GAIN:  state_nxt.gain    = pwdata[7:0];
				hct_pkg::HCT_SEL_RATIO: state_nxt.ratio   = pwdata[7:0];
				hct_pkg::HCT_SEL_SIN:   state_nxt.sin_ofs = pwdata[7:0];
				hct_pkg::HCT_SEL_COS:   state_nxt.cos_ofs = pwdata[7:0];
				hct_pkg::HCT_SEL_BIAS: begin
					state_nxt.bias_trim = pwdata[`HCT_BIAS_MSB:0];
					state_nxt.sclk_sel  = pwdata[`HCT_BIT_SCLK];
				end
				hct_pkg::HCT_SEL_TEST:  state_nxt.test_code = pwdata[7:0];
				default: begin
				end
			endcase
		end

		// A fuse load refreshes both copies and wins over a software write,
		// since it only happens after power-up or on a reload request.
		if (fuse_load_valid) begin
			state_nxt.bias_preset = fuse_bias_trim;
			state_nxt.bias_trim   = fuse_bias_trim;
		end

		// Decoded trims are registered so every output comes from a flop.
		state_nxt.sin_mv   = ofs_mv[0];
		state_nxt.cos_mv   = ofs_mv[1];
		state_nxt.bias_pct = 8'(8'({4'h0, state_r.bias_trim}) * `HCT_BIAS_STEP_PCT)
			- `HCT_BIAS_MIN_PCT;

		// Fine gain reads zero while the loop owns the second stage; both are flops.
		state_nxt.rot_shift    = state_nxt.cos_ofs[`HCT_BIT_PSAVE] ? `HCT_PSAVE_SHIFT
			: 2'h0;
		state_nxt.fine_applied = state_nxt.ratio[`HCT_BIT_AUTO] ? 6'h00
			: state_nxt.gain[5:0];

		// Test mode needs both the pin and a code; the code alone is held.
		state_nxt.test_active = programming_voltage_pin_at_supply
			&& (state_r.test_code != `HCT_TEST_NORMAL);
		state_nxt.route = state_nxt.test_active ? route_of(state_r.test_code)
			: hct_pkg::HCT_ROUTE_NORMAL;

		// Hall switching clock.
		if (state_r.sclk_sel) begin
			sclk_half = SCLK_HIGH_HALF;
		end
		if (state_r.sclk_cnt >= sclk_half - 8'h01) begin
			state_nxt.sclk_cnt = 8'h00;
			state_nxt.sclk     = !state_r.sclk;
		end else begin
			state_nxt.sclk_cnt = state_r.sclk_cnt + 8'h01;
		end

		// Bias-derived clock runs only in its test mode to save power.
		if (state_r.route != hct_pkg::HCT_ROUTE_CLK) begin
			state_nxt.bias_derived_clock_cnt = 8'h00;
			state_nxt.bias_derived_clock     = 1'b0;
		end else if (state_r.bias_derived_clock_cnt >= bias_derived_clock_half(state_r.bias_trim) - 8'h01) begin
			state_nxt.bias_derived_clock_cnt = 8'h00;
			state_nxt.bias_derived_clock     = !state_r.bias_derived_clock;
		end else begin
			state_nxt.bias_derived_clock_cnt = state_r.bias_derived_clock_cnt + 8'h01;
		end

		// Pin routing; analog modes release the digital drivers.
		case (state_r.route)
			hct_pkg::HCT_ROUTE_NORMAL: begin
				state_nxt.pin_a              = norm_a;
				state_nxt.pin_b              = norm_b;
				state_nxt.pin_z              = norm_z;
				state_nxt.pin_u              = norm_u;
				state_nxt.pin_digital_enable = 1'b1;
			end
			hct_pkg::HCT_ROUTE_CLK: begin
				state_nxt.pin_a              = state_r.bias_derived_clock;
				state_nxt.pin_b              = norm_b;
				state_nxt.pin_z              = norm_z;
				state_nxt.pin_u              = norm_u;
				state_nxt.pin_digital_enable = 1'b1;
			end
			default: begin
				state_nxt.pin_a              = 1'b0;
				state_nxt.pin_b              = 1'b0;
				state_nxt.pin_z              = 1'b0;
				state_nxt.pin_u              = 1'b0;
				state_nxt.pin_digital_enable = 1'b0;
			end
		endcase
	end

	// --------------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r                    <= '0;
			state_r.bias_trim          <= `HCT_BIAS_NOMINAL;
			state_r.bias_preset        <= `HCT_BIAS_NOMINAL;
			state_r.gain               <= `HCT_RST_REG;
			state_r.test_code          <= `HCT_TEST_NORMAL;
			state_r.route              <= hct_pkg::HCT_ROUTE_NORMAL;
			state_r.pin_digital_enable <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// --------------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------------
	assign prdata               = {24'h000000, state_r.prdata};
	assign pready               = state_r.pready;
	assign pslverr              = state_r.pslverr;
	assign pin_a                = state_r.pin_a;
	assign pin_b                = state_r.pin_b;
	assign pin_z                = state_r.pin_z;
	assign pin_u                = state_r.pin_u;
	assign pin_digital_enable   = state_r.pin_digital_enable;
	assign analog_route         = state_r.route;
	assign test_mode_active     = state_r.test_active;
	assign sine_offset_mv       = state_r.sin_mv;
	assign cosine_offset_mv     = state_r.cos_mv;
	assign power_save_flag      = state_r.cos_ofs[`HCT_BIT_PSAVE];
	assign rotation_limit_shift = state_r.rot_shift;
	assign bias_current_trim    = state_r.bias_trim;
	assign bias_current_pct     = state_r.bias_pct;
	assign sensor_clock_select  = state_r.sclk_sel;
	assign hall_switch_clk      = state_r.sclk;
	assign auto_amplitude_enable = state_r.ratio[`HCT_BIT_AUTO];
	assign coarse_gain          = state_r.gain[7:6];
	assign fine_gain_applied    = state_r.fine_applied;
	assign cosine_ratio_trim    = state_r.ratio[6:0];

endmodule

`default_nettype wire

// File: sim/hct_regs_checker.sv
/* Concurrent checks on the ports of the Hall calibration register bank.
 * Assumes it is bound into hct_regs and that pclk is the only clock. */
`default_nettype none

module hct_regs_checker (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pready,
	input wire logic                   norm_a,
	input wire logic                   norm_b,
	input wire logic                   pin_a,
	input wire logic                   pin_b,
	input wire logic                   pin_digital_enable,
	input wire hct_pkg::hct_route_type analog_route,
	input wire logic                   test_mode_active,
	input wire logic                   programming_voltage_pin_at_supply,
	input wire logic                   power_save_flag,
	input wire logic [1:0]             rotation_limit_shift,
	input wire logic [3:0]             bias_current_trim,
	input wire logic [7:0]             bias_current_pct,
	input wire logic                   auto_amplitude_enable,
	input wire logic [5:0]             fine_gain_applied
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_access;
		psel && penable && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	a_apb_one_wait: assert property (s_access |=> s_answer)
		else $error("access not answered after one wait cycle");
	a_psave_quarter: assert property (rotation_limit_shift == {power_save_flag, 1'b0})
		else $error("rotation limit does not follow power save");
	a_fine_ignored: assert property (auto_amplitude_enable |-> fine_gain_applied == 6'h00)
		else $error("fine gain applied under amplitude control");
	a_test_gated: assert property (!programming_voltage_pin_at_supply |=> !test_mode_active)
		else $error("test mode without programming pin");
	a_idle_normal: assert property (!test_mode_active |->
		analog_route == hct_pkg::HCT_ROUTE_NORMAL) else $error("route set outside test mode");
	a_bias_scale: assert property (1'b1 |=>
		bias_current_pct == {4'h0, $past(bias_current_trim)} * 8'h05 - 8'h28)
		else $error("bias percentage wrong for trim");
	a_pins_follow: assert property ($stable(analog_route) && $past(presetn) &&
		analog_route == hct_pkg::HCT_ROUTE_NORMAL |-> pin_digital_enable && pin_a == $past(norm_a))
		else $error("normal pin path broken");
	a_clk_keeps_b: assert property ($stable(analog_route) &&
		analog_route == hct_pkg::HCT_ROUTE_CLK |-> pin_digital_enable && pin_b == $past(norm_b))
		else $error("clock mode disturbs pin b");
	a_analog_quiet: assert property ($stable(analog_route) &&
		analog_route != hct_pkg::HCT_ROUTE_NORMAL && analog_route != hct_pkg::HCT_ROUTE_CLK
		|-> !pin_digital_enable && !pin_a && !pin_b) else $error("digital drive in analog mode");
endmodule

bind hct_regs hct_regs_checker chk (
	.pclk, .presetn, .psel, .penable, .pready, .norm_a, .norm_b, .pin_a, .pin_b,
	.pin_digital_enable, .analog_route, .test_mode_active, .programming_voltage_pin_at_supply,
	.power_save_flag, .rotation_limit_shift, .bias_current_trim, .bias_current_pct,
	.auto_amplitude_enable, .fine_gain_applied
);

`default_nettype wire

// File: sim/hct_test_rig.sv
/* Calibration rig beside the register bank: fuse loader, programming pin and
 * the normal incremental sources. Assumes the bench asks for pin and reload. */
`default_nettype none

module hct_test_rig #(
	parameter logic [3:0] FUSE_PRESET = 4'h3
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       zap_request,
	input  wire logic       reload_request,
	output logic            programming_voltage_pin_at_supply,
	output logic            fuse_load_valid,
	output logic      [3:0] fuse_bias_trim,
	output logic      [3:0] norm_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       loaded_r;

	// Outside a load the fuse lines show the inverse, so a stale value is caught.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r <= 1'b0;
			norm_bus <= 4'h0;
			fuse_load_valid <= 1'b0;
			fuse_bias_trim <= ~FUSE_PRESET;
			programming_voltage_pin_at_supply <= 1'b0;
		end else begin
			loaded_r <= 1'b1;
			norm_bus <= norm_bus + 4'h5;
			fuse_load_valid <= !loaded_r || reload_request;
			fuse_bias_trim <= (!loaded_r || reload_request) ? FUSE_PRESET : ~FUSE_PRESET;
			programming_voltage_pin_at_supply <= zap_request;
		end
	end
endmodule

`default_nettype wire

// File: sim/hct_tb.sv
/* Self-checking bench of the register bank: APB host, calibration rig, checker.
 * Assumes hct_map.svh on the include path and a 100 MHz pclk. */
`default_nettype none

`include "hct_map.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]             paddr, bias_current_pct;
	logic [31:0]            pwdata, prdata, seed;
	logic                   fuse_load_valid, programming_voltage_pin_at_supply;
	logic [3:0]             fuse_bias_trim, norm_bus, bias_current_trim, t;
	logic                   pin_a, pin_b, pin_z, pin_u, pin_digital_enable, test_mode_active;
	logic                   power_save_flag, sensor_clock_select, hall_switch_clk;
	logic                   auto_amplitude_enable, zap_request, reload_request, probe_sel;
	hct_pkg::hct_route_type analog_route;
	logic [6:0]             sine_offset_mv, cosine_offset_mv, cosine_ratio_trim, c;
	logic [1:0]             rotation_limit_shift, coarse_gain;
	logic [5:0]             fine_gain_applied;
	logic [33:0]            exp_q [$];
	logic [33:0]            e;
	int                     bad_count, tests_run;
	logic [5:0]  idx [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h0e, 6'h10, 6'h05};
	logic [7:0]  rst [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h30, 8'h00};
	logic [6:0]  edge_codes [4] = '{7'h3f, 7'h40, 7'h41, 7'h7f};
	logic [3:0]  tv [3] = '{4'h0, 4'h8, 4'hf};
	logic [7:0]  codes [7] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h43, 8'hc0, 8'h55};
	hct_pkg::hct_route_type routes [7] = '{hct_pkg::HCT_ROUTE_NORMAL, hct_pkg::HCT_ROUTE_SIN,
		hct_pkg::HCT_ROUTE_COS, hct_pkg::HCT_ROUTE_INTERP, hct_pkg::HCT_ROUTE_REF,
		hct_pkg::HCT_ROUTE_CLK, hct_pkg::HCT_ROUTE_NORMAL};
	wire logic probe = probe_sel ? pin_a : hall_switch_clk;

	hct_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fuse_load_valid, .fuse_bias_trim, .programming_voltage_pin_at_supply,
		.norm_a(norm_bus[0]), .norm_b(norm_bus[1]), .norm_z(norm_bus[2]), .norm_u(norm_bus[3]),
		.pin_a, .pin_b, .pin_z, .pin_u, .pin_digital_enable, .analog_route, .test_mode_active,
		.sine_offset_mv, .cosine_offset_mv, .power_save_flag, .rotation_limit_shift,
		.bias_current_trim, .bias_current_pct, .sensor_clock_select, .hall_switch_clk,
		.auto_amplitude_enable, .coarse_gain, .fine_gain_applied, .cosine_ratio_trim);
	hct_test_rig rig (.pclk, .presetn, .zap_request, .reload_request,
		.programming_voltage_pin_at_supply, .fuse_load_valid, .fuse_bias_trim, .norm_bus);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	function automatic logic [6:0] mv(input logic [6:0] code);
		return code[6] ? 7'h00 - {1'b0, code[5:0]} : {1'b0, code[5:0]};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// The note goes on the queue before the request, so the watcher always finds it.
	task automatic apb(input logic wr, input logic [5:0] a, input logic [7:0] wd,
		input logic [7:0] rd, input logic err);
		int n;
		@(posedge pclk);
		exp_q.push_back({!wr, err, 24'h0, rd});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {a, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("apb wait", 32'h0, 32'h1);
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Skips one toggle so a mode change cannot shorten the measured half period.
	task automatic half(input int want);
		int n;
		logic lv;
		for (int k = 0; k < 2; k++) begin
			lv = probe;
			n = 0;
			while (probe === lv && n < 1200) begin
				@(posedge pclk);
				n++;
			end
		end
		check("half period", 32'(n), 32'(want));
		if (n >= 1200) test_done();
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected answer", 32'h0, 32'h1);
			else begin
				e = exp_q.pop_front();
				check("pslverr", 32'(pslverr), 32'(e[32]));
				if (e[33]) check("prdata", prdata, e[31:0]);
			end
		end
	end

	initial begin
		repeat (60000) @(posedge pclk);
		check("watchdog", 32'h0, 32'h1);
		test_done();
	end

	initial begin
		{psel, penable, pwrite, zap_request, reload_request, probe_sel} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		seed = 32'h25f4660e;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		check("preset trim", 32'(bias_current_trim), 32'h3);
		for (int k = 0; k < 8; k++) apb(1'b0, idx[k], 8'h00, rst[k], k == 7);
		for (int k = 0; k < 10; k++) begin
			seed = xs(seed);
			c = (k < 4) ? edge_codes[k] : seed[6:0];
			apb(1'b1, 6'h02, {1'b0, c}, 8'h00, 1'b0);
			apb(1'b1, 6'h03, seed[15:8], 8'h00, 1'b0);
			repeat (2) @(posedge pclk);
			check("sine mv", 32'(sine_offset_mv), 32'(mv(c)));
			check("cosine mv", 32'(cosine_offset_mv), 32'(mv(seed[14:8])));
			check("power save", 32'(rotation_limit_shift), seed[15] ? 32'h2 : 32'h0);
			apb(1'b0, 6'h03, 8'h00, seed[15:8], 1'b0);
		end
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			t = (k < 3) ? tv[k] : seed[3:0];
			apb(1'b1, 6'h04, {4'h0, t}, 8'h00, 1'b0);
			repeat (2) @(posedge pclk);
			check("trim", 32'(bias_current_trim), 32'(t));
			check("pct", 32'(bias_current_pct), 32'(8'({4'h0, t} * 8'h05 - 8'h28)));
			apb(1'b0, 6'h10, 8'h00, 8'h30, 1'b0);
		end
		reload_request <= 1'b1;
		@(posedge pclk);
		reload_request <= 1'b0;
		repeat (4) @(posedge pclk);
		check("reloaded trim", 32'(bias_current_trim), 32'h3);
		apb(1'b1, 6'h04, 8'h08, 8'h00, 1'b0);
		half(`HCT_SCLK_LOW_HALF);
		apb(1'b1, 6'h04, 8'h88, 8'h00, 1'b0);
		half(`HCT_SCLK_HIGH_HALF);
		check("sclk sel", 32'(sensor_clock_select), 32'h1);
		apb(1'b1, 6'h0e, 8'h20, 8'h00, 1'b0);
		repeat (3) @(posedge pclk);
		check("gated", 32'(test_mode_active), 32'h0);
		zap_request <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, 6'h0e, codes[k], 8'h00, 1'b0);
			repeat (3) @(posedge pclk);
			check("active", 32'(test_mode_active), 32'(codes[k] != 8'h00));
			check("route", 32'(analog_route), 32'(routes[k]));
			check("driven", 32'(pin_digital_enable), 32'(k == 0 || k >= 5));
			if (k != 5) check("pins", 32'({pin_u, pin_z, pin_b, pin_a}),
				(k % 6 == 0) ? 32'(4'(norm_bus - 4'h5)) : 32'h0);
		end
		apb(1'b1, 6'h0e, 8'hc0, 8'h00, 1'b0);
		probe_sel <= 1'b1;
		// Let pin A leave the pass-through path before timing it.
		repeat (3) @(posedge pclk);
		half(`HCT_BIAS_DERIVED_CLOCK_NOM_HALF);
		apb(1'b1, 6'h04, 8'h8f, 8'h00, 1'b0);
		half(1000 / (12 + 15));
		apb(1'b1, 6'h01, 8'h15, 8'h00, 1'b0);
		apb(1'b1, 6'h00, 8'h60, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		check("fine", 32'(fine_gain_applied), 32'h20);
		check("coarse", 32'(coarse_gain), 32'h1);
		apb(1'b1, 6'h01, 8'h95, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		check("fine off", 32'(fine_gain_applied), 32'h0);
		check("ratio", 32'({auto_amplitude_enable, cosine_ratio_trim}), 32'h95);
		apb(1'b1, 6'h05, 8'hff, 8'h00, 1'b1);
		apb(1'b0, 6'h01, 8'h00, 8'h95, 1'b0);
		repeat (3) @(posedge pclk);
		test_done();
	end
endmodule

`default_nettype wire
